// ---- design/ecr_pkg.sv ----
// constants for the enhanced host extra configuration registers
package ecr_pkg;
  localparam logic [7:0]  ECR_OFS_RELEASE   = 8'h60;
  localparam logic [7:0]  ECR_OFS_FRAME_ADJ = 8'h61;
  localparam logic [7:0]  ECR_OFS_WAKE_LO   = 8'h62;
  localparam logic [7:0]  ECR_OFS_WAKE_HI   = 8'h63;
  localparam logic [7:0]  ECR_RELEASE_VAL   = 8'h20;
  localparam logic [5:0]  ECR_FRAME_ADJ_RST = 6'h20;
  localparam logic [15:0] ECR_WAKE_RST      = 16'h0007;
  localparam logic [15:0] ECR_FRAME_BASE    = 16'hE860;
  localparam logic [15:0] ECR_FRAME_LEN_RST = 16'hEA60;
  localparam int          ECR_FRAME_ADJ_LSB = 0;
  localparam int          ECR_FRAME_ADJ_MSB = 5;
  localparam int          ECR_FRAME_STEP_SH = 4;
endpackage

// ---- design/ecr_regs.sv ----
// extra configuration registers and micro-frame length generator
`timescale 1ns/1ps
module ecr_regs
  import ecr_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // configuration access, byte wide
  input  wire logic [7:0]  cfg_addr,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_wdata,
  output logic      [7:0]  cfg_rdata,
  // frame counter tick, one per counter clock
  input  wire logic        sof_tick,
  // frame and wake mask outputs
  output logic      [15:0] frame_len,
  output logic             sof_pulse,
  output logic      [15:0] port_wake_policy_mask
);

  // frame adjust byte
  logic [5:0]  frame_adjust_reg;
  logic [5:0]  frame_adjust_next;
  logic        wr_frame_adj;

  // wake mask bytes
  logic [7:0]  wake_lo_reg;
  logic [7:0]  wake_lo_next;
  logic [7:0]  wake_hi_reg;
  logic [7:0]  wake_hi_next;
  logic        wr_wake_lo;
  logic        wr_wake_hi;

  // read path
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;

  // frame generator
  logic [15:0] frame_cnt_reg;
  logic [15:0] frame_cnt_next;
  logic [15:0] frame_len_reg;
  logic [15:0] frame_len_next;
  logic        sof_reg;
  logic        sof_next;
  logic        frame_last;

  function automatic logic ecr_hit(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    ecr_hit = (addr == ofs);
  endfunction

  function automatic logic [15:0] ecr_frame_clocks(
    input logic [5:0] adj
  );
    logic [15:0] step;
    step             = 16'({10'h000, adj}) << ECR_FRAME_STEP_SH;
    ecr_frame_clocks = ECR_FRAME_BASE + step;
  endfunction

  function automatic logic [7:0] ecr_read_byte(
    input logic [7:0]  addr,
    input logic [5:0]  adj,
    input logic [15:0] mask
  );
    logic [7:0] rb;
    case (addr)
      ECR_OFS_RELEASE: begin
        rb = ECR_RELEASE_VAL;
      end
      ECR_OFS_FRAME_ADJ: begin
        rb = {2'b00, adj};
      end
      ECR_OFS_WAKE_LO: begin
        rb = mask[7:0];
      end
      ECR_OFS_WAKE_HI: begin
        rb = mask[15:8];
      end
      // unmapped offsets read as zero
      default: begin
        rb = 8'h00;
      end
    endcase
    ecr_read_byte = rb;
  endfunction

  // release byte has no write decode, so it cannot change
  always_comb begin
    wr_frame_adj = cfg_wr && ecr_hit(cfg_addr, ECR_OFS_FRAME_ADJ);
    wr_wake_lo   = cfg_wr && ecr_hit(cfg_addr, ECR_OFS_WAKE_LO);
    wr_wake_hi   = cfg_wr && ecr_hit(cfg_addr, ECR_OFS_WAKE_HI);
  end

  // frame ends on the tick that completes frame_len counts
  always_comb begin
    frame_last = sof_tick && (frame_cnt_reg >= frame_len_reg - 16'h0001);
  end

  // reserved bits 7:6 are not stored, software keeps them zero
  always_comb begin
    frame_adjust_next = frame_adjust_reg;
    if (wr_frame_adj) begin
      frame_adjust_next = cfg_wdata[ECR_FRAME_ADJ_MSB:ECR_FRAME_ADJ_LSB];
    end
  end

  // mask only stored and reported, nothing else reads it
  always_comb begin
    wake_lo_next = wake_lo_reg;
    if (wr_wake_lo) begin
      wake_lo_next = cfg_wdata;
    end
  end

  always_comb begin
    wake_hi_next = wake_hi_reg;
    if (wr_wake_hi) begin
      wake_hi_next = cfg_wdata;
    end
  end

  // read data holds until the next read strobe
  always_comb begin
    rdata_next = rdata_reg;
    if (cfg_rd) begin
      rdata_next = ecr_read_byte(cfg_addr, frame_adjust_reg, {wake_hi_reg, wake_lo_reg});
    end
  end

  // counts ticks only; a stalled tick stretches the frame
  always_comb begin
    frame_cnt_next = frame_cnt_reg;
    if (frame_last) begin
      frame_cnt_next = 16'h0000;
    end else if (sof_tick) begin
      frame_cnt_next = frame_cnt_reg + 16'h0001;
    end
  end

  // length latched only at wrap so the running frame keeps its length
  always_comb begin
    frame_len_next = frame_len_reg;
    if (frame_last) begin
      frame_len_next = ecr_frame_clocks(frame_adjust_reg);
    end
  end

  // one-cycle start-of-frame pulse
  always_comb begin
    sof_next = frame_last;
  end

  // one flop group per concern
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_adjust_reg <= ECR_FRAME_ADJ_RST;
    end else begin
      frame_adjust_reg <= frame_adjust_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_lo_reg <= ECR_WAKE_RST[7:0];
    end else begin
      wake_lo_reg <= wake_lo_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_hi_reg <= ECR_WAKE_RST[15:8];
    end else begin
      wake_hi_reg <= wake_hi_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // counter clears on reset so the first frame starts aligned
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt_reg <= 16'h0000;
    end else begin
      frame_cnt_reg <= frame_cnt_next;
    end
  end

  // first frame after reset runs the default length
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_len_reg <= ECR_FRAME_LEN_RST;
    end else begin
      frame_len_reg <= frame_len_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sof_reg <= 1'b0;
    end else begin
      sof_reg <= sof_next;
    end
  end

  // outputs straight from flops
  assign cfg_rdata             = rdata_reg;
  assign frame_len             = frame_len_reg;
  assign sof_pulse             = sof_reg;
  assign port_wake_policy_mask = {wake_hi_reg, wake_lo_reg};

endmodule

// ---- dv/ecr_regs_asserts.sv ----
// checker for the extra configuration registers
`timescale 1ns/1ps
module ecr_chk
  import ecr_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // configuration access
  input wire logic [7:0]  cfg_addr,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_wdata,
  input wire logic [7:0]  cfg_rdata,
  // frame and mask outputs
  input wire logic [15:0] frame_len,
  input wire logic        sof_pulse,
  input wire logic [15:0] port_wake_policy_mask
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  rel_fixed_a: assert property (cfg_rd && cfg_addr == ECR_OFS_RELEASE
    |=> cfg_rdata == ECR_RELEASE_VAL) else $error("release byte");
  adj_six_a: assert property (cfg_rd && cfg_addr == ECR_OFS_FRAME_ADJ
    |=> cfg_rdata[7:6] == 2'b00) else $error("adjust upper bits");
  len_form_a: assert property (frame_len[3:0] == 4'h0
    && frame_len >= ECR_FRAME_BASE && frame_len <= 16'hEC50) else $error("length form");
  len_edge_a: assert property ($changed(frame_len)
    |-> sof_pulse || $past(sof_pulse)) else $error("length mid-frame");
  sof_one_a: assert property (sof_pulse |=> !sof_pulse) else $error("long pulse");
  mask_lo_wr_a: assert property (cfg_wr && cfg_addr == ECR_OFS_WAKE_LO
    |=> port_wake_policy_mask[7:0] == $past(cfg_wdata)) else $error("mask write");
  mask_hold_a: assert property (!cfg_wr
    |=> $stable(port_wake_policy_mask)) else $error("mask changed");
endmodule

// ---- dv/ecr_host.sv ----
// host software model issuing configuration cycles
`timescale 1ns/1ps
module ecr_host (input wire logic mclk, output logic [7:0] a, d, output logic w, r);
  initial {a, d, w, r} = '0;
  // callers keep bits 7:6 of the adjust byte zero
  task automatic acc(input logic wr, input logic [7:0] ad, dt);
    @(posedge mclk); a <= ad; d <= dt; w <= wr; r <= !wr;
    @(posedge mclk); w <= 0; r <= 0;
  endtask
endmodule

// ---- dv/ecr_regs_tb_top.sv ----
// bench for the extra configuration registers
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module ecr_regs_tb_top import ecr_pkg::*;;
  logic mclk = 0, rst_n = 0, tick = 0, w, r, sof;
  logic [7:0] a, d, q;
  logic [15:0] fl, pm, mask = 16'h0007;
  logic [5:0] adj;
  int bad_count, compares, seed = 3210, v;
  initial forever #50 mclk = ~mclk;
  ecr_host host (.mclk(mclk), .a(a), .d(d), .w(w), .r(r));
  ecr_regs uut (.mclk(mclk), .rst_n(rst_n), .cfg_addr(a), .cfg_wr(w), .cfg_rd(r),
    .cfg_wdata(d), .cfg_rdata(q), .sof_tick(tick), .frame_len(fl), .sof_pulse(sof),
    .port_wake_policy_mask(pm));
  task automatic rd(input logic [7:0] ad, e);
    host.acc(0, ad, 8'h00); #1 `CHK(q, e)
  endtask
  task wrap_up;
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one frame of 60000 ticks dominates the run
  initial begin #9e6 bad_count++; wrap_up; end
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    `CHK(fl, 16'd60000)
    host.acc(1, 8'h60, 8'h00); rd(8'h60, 8'h20);
    rd(8'h62, mask[7:0]); rd(8'h64, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed); host.acc(1, 8'h62 + i[0], v[7:0]); mask[8*i[0] +: 8] = v[7:0];
      rd(8'h62 + i[0], v[7:0]);
    end
    `CHK(pm, mask)
    v = $random(seed); adj = v[5:0]; host.acc(1, 8'h61, {2'b00, adj});
    rd(8'h61, {2'b00, adj}); `CHK(fl, 16'd60000)
    @(posedge mclk); tick <= 1; v = 0;
    while (sof !== 1'b1 && v < 70000) begin @(posedge mclk); #1; v++; end
    `CHK(v, 60000)
    repeat (2) @(posedge mclk);
    `CHK(fl, 16'd59488 + 16 * adj)
    `CHK(pm, mask)
    wrap_up;
  end
endmodule
bind ecr_regs ecr_chk chk (.mclk, .rst_n, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata,
  .frame_len, .sof_pulse, .port_wake_policy_mask);
